// *** core/psrc_top.sv ***
// psrc_top: strap capture, reset-time pin float, isolate release and config registers over APB.
// assumes straps are resolved by board and internal pulls while pins float; inputs synchronous to pclk.
//
// How it works
// [R1] straps sampled during reset select modes
// [R2] five address straps latched into station address
// [R3] all 32 station addresses are accepted
// [R4] unstrapped address defaults to one
// [R5] duplex strap high full, low half
// [R6] reset defaults: autoneg on, 100 Mb/s
// [R7] led strap picks link led mode
// [R8] crossover enabled unless strapped low
// [R9] mode strap low MII, high RMII
// [R10] leave isolate 71 ns after reset release
// [R11] shared pins float while reset held
// [R12] after reset pins resume functional roles
// [R13] host pulses reset after power-up
// [R14] software may shut the regulator down
// [R15] duplex strap seeds advertisement bits 8:5
// [R16] isolate ignores tx, floats MII outputs
// [R17] latched straps hold until next reset
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module psrc_top #(
    parameter int unsigned BLINK_CYCLES = psrc_pkg::BLINK_CYCLES
) (
    // clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [psrc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    // shared pins
    input  wire logic [psrc_pkg::NUM_PINS-1:0] pin_i,
    output logic [psrc_pkg::NUM_PINS-1:0]      pin_o,
    output logic [psrc_pkg::NUM_PINS-1:0]      pin_oe_n,
    // functional data for the shared pins
    input  wire logic [3:0]                   func_rxd,
    input  wire logic                         func_col,
    input  wire logic                         func_crs,
    input  wire logic                         func_rx_er,
    input  wire logic                         func_rx_dv,
    input  wire logic                         func_tx_clk,
    input  wire logic                         func_rx_clk,
    input  wire logic                         func_int_n,
    input  wire logic                         func_mdio_o,
    input  wire logic                         func_mdio_oe_n,
    input  wire logic                         link_up,
    input  wire logic                         activity,
    // transmit path from the mac
    input  wire logic [3:0]                   mii_txd,
    input  wire logic                         mii_tx_en,
    output logic [3:0]                        txd_core,
    output logic                              tx_en_core,
    // configuration to the core
    output logic [4:0]                        station_addr,
    output logic                              autoneg_en,
    output logic                              speed_100,
    output logic [3:0]                        advert_abil,
    output logic                              xover_en,
    output logic                              led_mode1,
    output logic                              rmii_mode,
    output logic                              isolate,
    output logic                              regulator_off,
    output logic                              config_ready
);

    // ==========================================================
    // state and registers
    psrc_pkg::psrc_state_e state_ff, nxt_state;
    logic [4:0]  addr_ff;
    logic        duplex_ff;
    logic        led_strap_ff;
    logic        xover_strap_ff;
    logic        rmii_ff;
    logic        an_en_ff;
    logic        speed_ff;
    logic        isolate_ff;
    logic [3:0]  advert_ff;
    logic        xover_ff;
    logic        led_ff;
    logic        reg_off_ff;
    logic [31:0] prdata_ff;
    logic        blink_ff;
    logic [3:0]  txd_ff;
    logic        tx_en_ff;

    // ==========================================================
    // reset sequencing
    logic settle_tick;
    logic blink_tick;
    wire  sampling   = (state_ff == psrc_pkg::ST_SAMPLE);
    wire  running    = (state_ff == psrc_pkg::ST_RUN);

    psrc_tick #(
        .LIMIT (psrc_pkg::SETTLE_CYCLES)
    ) u_settle (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_ff == psrc_pkg::ST_SETTLE),
        .tick    (settle_tick)
    );

    psrc_tick #(
        .LIMIT (BLINK_CYCLES)
    ) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (running),
        .tick    (blink_tick)
    );

    // ==========================================================
    // apb decode
    wire        acc      = psel & penable;
    wire        wr_acc   = acc & pwrite;
    wire        rd_setup = psel & ~penable & ~pwrite;
    wire [9:0]  widx     = paddr[11:2];
    wire        aligned  = (paddr[1:0] == 2'h0);
    wire        hit_ctrl = aligned & (widx == psrc_pkg::IDX_CTRL);
    wire        hit_adv  = aligned & (widx == psrc_pkg::IDX_ADVERT);
    wire        hit_stat = aligned & (widx == psrc_pkg::IDX_STATUS);
    wire        hit_phy  = aligned & (widx == psrc_pkg::IDX_PHY_CTRL);
    wire        hit_reg  = aligned & (widx == psrc_pkg::IDX_REG_CTRL);
    wire        mapped   = hit_ctrl | hit_adv | hit_stat | hit_phy | hit_reg;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    wire [31:0] ctrl_rd = {16'h0000, 1'b0, 1'b0, speed_ff, an_en_ff, 1'b0, isolate_ff, 10'h000};
    wire [31:0] adv_rd  = {23'h000000, advert_ff, 5'h00};
    wire [31:0] stat_rd = {21'h000000, running, isolate_ff, rmii_ff, xover_strap_ff, led_strap_ff,
                           duplex_ff, addr_ff};
    wire [31:0] phy_rd  = {16'h0000, xover_ff, 9'h000, led_ff, 5'h00};
    wire [31:0] reg_rd  = {16'h0000, reg_off_ff, 15'h0000};
    wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                          hit_adv  ? adv_rd  :
                          hit_stat ? stat_rd :
                          hit_phy  ? phy_rd  :
                          hit_reg  ? reg_rd  : 32'h00000000;

    wire [31:0] ctrl_wv = merge(ctrl_rd, pwdata, pstrb);
    wire [31:0] adv_wv  = merge(adv_rd, pwdata, pstrb);
    wire [31:0] phy_wv  = merge(phy_rd, pwdata, pstrb);
    wire [31:0] reg_wv  = merge(reg_rd, pwdata, pstrb);
    wire        wr_ctrl = wr_acc & hit_ctrl;
    wire        soft_rst = wr_ctrl & ctrl_wv[psrc_pkg::CTRL_SOFT_RST];

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = prdata_ff;

    // ==========================================================
    // sequence: float, sample, settle, run
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            psrc_pkg::ST_FLOAT:  nxt_state = psrc_pkg::ST_SAMPLE;
            psrc_pkg::ST_SAMPLE: nxt_state = psrc_pkg::ST_SETTLE;
            psrc_pkg::ST_SETTLE: nxt_state = settle_tick ? psrc_pkg::ST_RUN : psrc_pkg::ST_SETTLE; // see [R10]
            psrc_pkg::ST_RUN:    nxt_state = psrc_pkg::ST_RUN;
            default:             nxt_state = psrc_pkg::ST_FLOAT;
        endcase
        if (soft_rst) begin
            nxt_state = psrc_pkg::ST_FLOAT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= psrc_pkg::ST_FLOAT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // strap latches: only written while sampling, so later pin traffic is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff        <= psrc_pkg::DEF_ADDR;       // see [R4]
            duplex_ff      <= psrc_pkg::DEF_DUPLEX;
            led_strap_ff   <= psrc_pkg::DEF_LED_MODE1;
            xover_strap_ff <= psrc_pkg::DEF_XOVER;
            rmii_ff        <= psrc_pkg::DEF_RMII;
        end else if (sampling) begin                    // see [R1] [R17]
            addr_ff        <= {pin_i[3:0], pin_i[psrc_pkg::PIN_COL]}; // see [R2] [R3]
            duplex_ff      <= pin_i[psrc_pkg::PIN_LED];       // see [R5]
            led_strap_ff   <= pin_i[psrc_pkg::PIN_CRS];       // see [R7]
            xover_strap_ff <= pin_i[psrc_pkg::PIN_RX_ER];     // see [R8]
            rmii_ff        <= pin_i[psrc_pkg::PIN_RX_DV];     // see [R9]
        end
    end

    // ==========================================================
    // software registers; capture seeds advert_ff, xover_ff and led_ff, soft reset restores an_en_ff, speed_ff and isolate_ff, reg_off_ff keeps its value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_en_ff   <= psrc_pkg::DEF_AN_EN;              // see [R6]
            speed_ff   <= psrc_pkg::DEF_SPEED_100;
            isolate_ff <= 1'b0;
            advert_ff  <= psrc_pkg::ADVERT_FULL;
            xover_ff   <= psrc_pkg::DEF_XOVER;
            led_ff     <= psrc_pkg::DEF_LED_MODE1;
            reg_off_ff <= 1'b0;
        end else if (soft_rst) begin
            an_en_ff   <= psrc_pkg::DEF_AN_EN;
            speed_ff   <= psrc_pkg::DEF_SPEED_100;
            isolate_ff <= 1'b0;
        end else if (sampling) begin
            advert_ff  <= pin_i[psrc_pkg::PIN_LED] ? psrc_pkg::ADVERT_FULL : psrc_pkg::ADVERT_HALF; // see [R15]
            xover_ff   <= pin_i[psrc_pkg::PIN_RX_ER];
            led_ff     <= pin_i[psrc_pkg::PIN_CRS];
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                an_en_ff   <= ctrl_wv[psrc_pkg::CTRL_AN_EN];
                speed_ff   <= ctrl_wv[psrc_pkg::CTRL_SPEED];
                isolate_ff <= ctrl_wv[psrc_pkg::CTRL_ISOLATE];
            end
            if (hit_adv) begin
                advert_ff <= adv_wv[psrc_pkg::ADVERT_LSB +: 4];
            end
            if (hit_phy) begin
                xover_ff <= phy_wv[psrc_pkg::PHY_CTRL_XOVER];
                led_ff   <= phy_wv[psrc_pkg::PHY_CTRL_LED];  // see [R7]
            end
            if (hit_reg) begin
                reg_off_ff <= reg_wv[psrc_pkg::REG_CTRL_OFF]; // see [R14]
            end
        end
    end

    // read data is loaded in the setup cycle so pready can stay high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_ff <= rd_mux;
        end
    end

    // ==========================================================
    // link led and transmit gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_ff <= 1'b0;
        end else if (blink_tick) begin
            blink_ff <= ~blink_ff;
        end
    end

    wire led_val = led_ff ? link_up : (link_up & ~(activity & blink_ff)); // see [R7]
    wire tx_open = running & ~isolate_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_ff   <= 4'h0;
            tx_en_ff <= 1'b0;
        end else begin
            txd_ff   <= tx_open ? mii_txd : 4'h0;     // see [R16]
            tx_en_ff <= tx_open & mii_tx_en;
        end
    end

    // ==========================================================
    // pins: all float until running, MII group floats while isolated
    wire [psrc_pkg::NUM_PINS-1:0] hiz = !running  ? psrc_pkg::ALL_PINS :  // see [R11]
                                        isolate_ff ? psrc_pkg::MII_MASK :  // see [R16]
                                        {psrc_pkg::NUM_PINS{1'b0}};        // see [R12]
    wire [psrc_pkg::NUM_PINS-1:0] fo = {func_mdio_o, func_int_n, func_rx_clk, func_tx_clk, func_rx_dv,
                                        func_rx_er, func_crs, led_val, func_col, func_rxd};
    wire [psrc_pkg::NUM_PINS-1:0] foe_n = {func_mdio_oe_n, {(psrc_pkg::NUM_PINS - 1){1'b0}}};

    psrc_pad_bank #(
        .N (psrc_pkg::NUM_PINS)
    ) u_pads (
        .pclk      (pclk),
        .presetn   (presetn),
        .hiz       (hiz),
        .func_o    (fo),
        .func_oe_n (foe_n),
        .pin_o     (pin_o),
        .pin_oe_n  (pin_oe_n)
    );

    assign station_addr  = addr_ff;
    assign autoneg_en    = an_en_ff;
    assign speed_100     = speed_ff;
    assign advert_abil   = advert_ff;
    assign xover_en      = xover_ff;
    assign led_mode1     = led_ff;
    assign rmii_mode     = rmii_ff;
    assign isolate       = isolate_ff | ~running;
    assign regulator_off = reg_off_ff;
    assign config_ready  = running;
    assign txd_core      = txd_ff;
    assign tx_en_core    = tx_en_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hiz_sample;
        sampling |-> (pin_oe_n == psrc_pkg::ALL_PINS);
    endproperty
    a_hiz_sample: assert property (p_hiz_sample) else $error("pins driven while sampling straps"); // see [R11]

    property p_settle;
        $rose(state_ff == psrc_pkg::ST_SETTLE) |-> (state_ff == psrc_pkg::ST_SETTLE)[*2] ##1 running;
    endproperty
    a_settle: assert property (p_settle) else $error("isolate release not two cycles after sampling"); // see [R10]

    property p_addr_capture;
        sampling |=> (station_addr == {$past(pin_i[3:0]), $past(pin_i[psrc_pkg::PIN_COL])});
    endproperty
    a_addr_capture: assert property (p_addr_capture) else $error("station address not latched"); // see [R2]

    property p_hold;
        running && $past(running) && !soft_rst |=> $stable(station_addr) && $stable(rmii_mode);
    endproperty
    a_hold: assert property (p_hold) else $error("latched strap changed while running"); // see [R17]

    property p_advert;
        sampling |=> (advert_abil == ($past(pin_i[psrc_pkg::PIN_LED]) ? 4'hf : 4'h5));
    endproperty
    a_advert: assert property (p_advert) else $error("advertisement not seeded from duplex strap"); // see [R15]

    property p_modes;
        sampling |=> (xover_en == $past(pin_i[psrc_pkg::PIN_RX_ER])) && (rmii_mode == $past(pin_i[psrc_pkg::PIN_RX_DV]));
    endproperty
    a_modes: assert property (p_modes) else $error("crossover or interface mode not latched"); // see [R8]

    property p_isolate;
        running && isolate_ff |=> ((pin_oe_n & psrc_pkg::MII_MASK) == psrc_pkg::MII_MASK) && !tx_en_core;
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolate did not float mii outputs"); // see [R16]

    property p_release;
        running && !isolate_ff |=> !pin_oe_n[psrc_pkg::PIN_LED] && !pin_oe_n[psrc_pkg::PIN_RXD0];
    endproperty
    a_release: assert property (p_release) else $error("pins not returned after reset"); // see [R12]

    property p_led_mode1;
        running && led_ff |=> (pin_o[psrc_pkg::PIN_LED] == $past(link_up));
    endproperty
    a_led_mode1: assert property (p_led_mode1) else $error("link led does not follow link in mode 1"); // see [R7]

    c_run:      cover property ($rose(running));
    c_soft_rst: cover property (running ##1 soft_rst ##1 state_ff == psrc_pkg::ST_FLOAT);
    c_isolate:  cover property (running && isolate_ff);
    c_rmii:     cover property (sampling ##1 rmii_mode);

endmodule // psrc_top

// *** core/psrc_pkg.sv ***
// psrc_pkg: constants of the strap and reset configuration block.
// assumes one 25 MHz clock; register indices are word numbers, byte address is four times the index.
package psrc_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int CLK_HZ         = 25_000_000;
    localparam int T_SETTLE_NS    = 71;
    // least time, so round up to whole cycles
    localparam int SETTLE_CYCLES  = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLINK_HZ       = 5;
    localparam int BLINK_CYCLES   = CLK_HZ / (2 * BLINK_HZ);

    // ==========================================================
    // register indices
    localparam int          ADDR_W       = 12;
    localparam logic [9:0]  IDX_CTRL     = 10'h000;
    localparam logic [9:0]  IDX_ADVERT   = 10'h004;
    localparam logic [9:0]  IDX_STATUS   = 10'h010;
    localparam logic [9:0]  IDX_PHY_CTRL = 10'h019;
    localparam logic [9:0]  IDX_REG_CTRL = 10'h0d0;

    // ==========================================================
    // field positions
    localparam int CTRL_SOFT_RST  = 15;
    localparam int CTRL_SPEED     = 13;
    localparam int CTRL_AN_EN     = 12;
    localparam int CTRL_ISOLATE   = 10;
    localparam int ADVERT_LSB     = 5;
    localparam int PHY_CTRL_XOVER = 15;
    localparam int PHY_CTRL_LED   = 5;
    localparam int REG_CTRL_OFF   = 15;
    localparam int ST_DUPLEX      = 5;
    localparam int ST_LED         = 6;
    localparam int ST_XOVER       = 7;
    localparam int ST_RMII        = 8;
    localparam int ST_ISOLATE     = 9;
    localparam int ST_RUNNING     = 10;

    // ==========================================================
    // reset values and encodings
    localparam logic [3:0] ADVERT_FULL    = 4'hf;
    localparam logic [3:0] ADVERT_HALF    = 4'h5;
    localparam logic [4:0] DEF_ADDR       = 5'h01;
    localparam logic       DEF_DUPLEX     = 1'h1;
    localparam logic       DEF_LED_MODE1  = 1'h1;
    localparam logic       DEF_XOVER      = 1'h1;
    localparam logic       DEF_RMII       = 1'h0;
    localparam logic       DEF_AN_EN      = 1'h1;
    localparam logic       DEF_SPEED_100  = 1'h1;

    // ==========================================================
    // shared pin positions
    localparam int          NUM_PINS   = 13;
    localparam int          PIN_RXD0   = 0;
    localparam int          PIN_COL    = 4;
    localparam int          PIN_LED    = 5;
    localparam int          PIN_CRS    = 6;
    localparam int          PIN_RX_ER  = 7;
    localparam int          PIN_RX_DV  = 8;
    localparam int          PIN_TX_CLK = 9;
    localparam int          PIN_RX_CLK = 10;
    localparam int          PIN_INT    = 11;
    localparam int          PIN_MDIO   = 12;
    localparam logic [12:0] MII_MASK   = 13'h07df;
    localparam logic [12:0] ALL_PINS   = 13'h1fff;

    typedef enum logic [1:0] {ST_FLOAT, ST_SAMPLE, ST_SETTLE, ST_RUN} psrc_state_e;

endpackage

// *** core/psrc_tick.sv ***
// psrc_tick: counter that pulses once every LIMIT cycles while run is high.
// assumes run drops to restart the count from zero.
`timescale 1ns/10ps
module psrc_tick #(
    parameter int unsigned LIMIT = 2,
    parameter int unsigned CNT_W = $clog2(LIMIT + 1)
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic run,
    output logic      tick
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    wire              last = (cnt_ff == CNT_W'(LIMIT - 1));

    assign tick    = run & last;
    assign nxt_cnt = (!run || last) ? '0 : cnt_ff + CNT_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule // psrc_tick

// *** core/psrc_pad_bank.sv ***
// psrc_pad_bank: registered output and enable for each shared pin.
// assumes the bench resolves each wire from pin_o, pin_oe_n and the board pulls.
`timescale 1ns/10ps
module psrc_pad_bank #(
    parameter int unsigned N = 13
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // functional side
    input  wire logic [N-1:0] hiz,
    input  wire logic [N-1:0] func_o,
    input  wire logic [N-1:0] func_oe_n,
    // pad side
    output logic [N-1:0]      pin_o,
    output logic [N-1:0]      pin_oe_n
);

    // ==========================================================
    // one flop pair per pin; reset floats every pin at once
    for (genvar i = 0; i < N; i++) begin : g_pad
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_o[i]    <= 1'b0;
                pin_oe_n[i] <= 1'b1;
            end else begin
                pin_o[i]    <= func_o[i];
                pin_oe_n[i] <= hiz[i] | func_oe_n[i];
            end
        end
    end

endmodule // psrc_pad_bank

// *** tb/psrc_board.sv ***
// psrc_board: board pulls and strap resistors on the shared pins.
// assumes strap resistors are weaker than the device drivers.
`timescale 1ns/10ps
module psrc_board (
    // device side
    input  wire logic [12:0] pin_o,
    input  wire logic [12:0] pin_oe_n,
    // strap resistors
    input  wire logic [8:0]  strap_en,
    input  wire logic [8:0]  strap_val,
    output logic [12:0]      pin_i
);
    // ==========================================
    // pin resolution
    // no pull on 9, 10, 12: released lines show the inverse, never a stale copy
    localparam logic [12:0] PULL_UP = 13'h08f0;
    localparam logic [12:0] FLOATS  = 13'h1600;
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            if (!pin_oe_n[i])
                pin_i[i] = pin_o[i];
            else if (i < 9 && strap_en[i % 9])
                pin_i[i] = strap_val[i % 9];
            else if (FLOATS[i])
                pin_i[i] = ~pin_o[i];
            else
                pin_i[i] = PULL_UP[i];
        end
    end
endmodule // psrc_board

// *** tb/phy_strap_reset_config_bench.sv ***
// phy_strap_reset_config_bench: strap capture, pin float and register checks.
// assumes apb answers with no wait states but never counts on it.
`timescale 1ns/10ps
module phy_strap_reset_config_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 4'hf, func_rxd = 4'h5, mii_txd = 4'hf, txd_core, advert_abil;
    logic func_col = 1, func_crs = 0, func_rx_er = 1, func_rx_dv = 0, func_tx_clk = 1, func_rx_clk = 0;
    logic func_int_n = 1, func_mdio_o = 0, func_mdio_oe_n = 1, link_up = 1, activity = 0, mii_tx_en = 1;
    logic pready, pslverr, tx_en_core, autoneg_en, speed_100, xover_en, led_mode1, rmii_mode;
    logic isolate, regulator_off, config_ready, er;
    logic [4:0]  station_addr;
    logic [12:0] pin_i, pin_o, pin_oe_n;
    logic [8:0]  strap_en = 0, strap_val = 0;
    logic [29:0] rows [4] = '{{9'h000, 9'h000, 12'h0fe}, {9'h1ff, 9'h1ff, 12'hfff},
                              {9'h1ff, 9'h000, 12'h028}, {9'h01f, 9'h003, 12'h37e}};
    int fails = 0, n_tests = 0, cyc = 0, lows = 0;

    psrc_top #(.BLINK_CYCLES(4)) u_dut (.*);
    psrc_board u_board (.*);

    always #20 pclk = ~pclk;

    // ==========================================
    // shared tasks
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // host pulses reset after power-up
    task automatic hard_reset();
        @(posedge pclk);
        presetn <= 0;
        repeat (12) @(posedge pclk);
        chk("oe_n in reset", pin_oe_n, 13'h1fff);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        #1 chk("ready", {config_ready, isolate}, 2'b10);
        @(posedge pclk);
        #1 chk("oe_n run", pin_oe_n & 13'h07df, 13'h0000);
        chk("pin_o run", pin_o, 13'h0ab5);
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 4000) begin
            fails++;
            stop_test();
        end
    end

    // ==========================================
    // strap table, then awkward cases
    initial begin
        foreach (rows[i]) begin
            strap_en <= rows[i][29:21];
            strap_val <= rows[i][20:12];
            hard_reset();
            chk("straps", {station_addr, advert_abil, led_mode1, xover_en, rmii_mode}, rows[i][11:0]);
            chk("defaults", {autoneg_en, speed_100}, 2'b11);
        end
        strap_val <= 9'h1fc;
        repeat (3) @(posedge pclk);
        chk("latched addr", station_addr, 5'h06);
        apb(0, 12'h040, 0);
        chk("status", {rd[10], rd[4:0], er}, {1'b1, 5'h06, 1'b0});
        apb(1, 12'h000, 32'h3400);
        repeat (2) @(posedge pclk);
        #1 chk("isolated", {isolate, tx_en_core, txd_core, pin_oe_n & 13'h07df}, {6'h20, 13'h07df});
        apb(1, 12'h000, 32'h3000);
        repeat (2) @(posedge pclk);
        #1 chk("released", {isolate, tx_en_core, txd_core}, 6'h1f);
        apb(1, 12'h340, 32'h8000);
        #1 chk("regulator", regulator_off, 1'b1);
        apb(0, 12'h044, 0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped rd", rd, 32'h00000000);
        // led mode 2 by register: dark for half of each blink period
        apb(1, 12'h064, 32'h8000);
        activity <= 1;
        repeat (16) begin
            @(posedge pclk);
            #1 lows += !pin_o[5];
        end
        chk("led mode", led_mode1, 1'b0);
        chk("blink lows", lows, 8);
        // soft reset floats the pins, recaptures straps and reruns the settle
        apb(1, 12'h000, 32'h8000);
        repeat (4) @(posedge pclk);
        #1 chk("soft reset", {config_ready, station_addr}, 6'h39);
        stop_test();
    end
endmodule // phy_strap_reset_config_bench
